// ===== pex_consts.svh
// constants for the octal port expander
`ifndef PEX_CONSTS_SVH
`define PEX_CONSTS_SVH
`define PEX_ADDR_HI 4'h7
`define PEX_REG_IN 2'h0
`define PEX_REG_OUT 2'h1
`define PEX_REG_POL 2'h2
`define PEX_REG_DIR 2'h3
`define PEX_OUT_RST 8'hff
`define PEX_POL_RST 8'h00
`define PEX_DIR_RST 8'hff
`define PEX_BIT_LAST 3'h7
`define PEX_IDX_ADDR 2'h0
`define PEX_IDX_CMD 2'h1
`define PEX_IDX_DATA 2'h2
`endif

// ===== pex_pkg.sv
// types for the octal port expander
package pex_pkg;
    typedef enum {st_idle, st_rx, st_ack_wait, st_ack, st_tx, st_mack} pex_state_t;
endpackage

// ===== pex_port_expander.sv
// serial-controlled eight-pin port expander with change alert
`timescale 1ns/1ps
`include "pex_consts.svh"

// Behaviour
// - after reset all eight pins are inputs, drivers off, pull-up on.
// - the master sets each pin's direction through the direction register.
// - an input register and an output register hold one bit per pin.
// - input reads are inverted per pin where the polarity bit is set.
// - input, output, polarity and direction registers are all readable.
// - reset restores register defaults and the serial state machine.
// - alert is driven low while any pin differs from the input register.
// - three strap pins give the low address bits, eight devices per bus.
// - an input pin has both drivers off and only the weak pull-up.
// - an output pin turns on the high or low driver per its output bit.
// - outputs hold their last written value until rewrite or reset.
// - the slave address is 0111 then the straps; the last bit set means read.
// - the command byte's two low bits pick the register 0 to 3.
// - direction bit 1 makes an input, 0 makes an output.
// - the last command byte stays the read target until a new one or reset.
module pex_port_expander
    import pex_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    // port pins
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe,
    output logic [7:0] high_side_driver,
    output logic [7:0] low_side_driver,
    output logic [7:0] weak_pullup_en,
    // alert, open drain
    output logic alert_out,
    output logic alert_oe
);

////////////////////////////////////////////////////////////////////////////
// link domain: data bit caught on the serial clock's rising edge

logic link_bit;
logic next_link_bit;

always_comb begin
    next_link_bit = sda_in;
end

// held until the next rising edge, read only after the edge is seen in clk
always_ff @(posedge scl) begin
    link_bit <= next_link_bit;
end

////////////////////////////////////////////////////////////////////////////
// synchronisers into clk

logic scl_s1, scl_s2, scl_q;
logic sda_s1, sda_s2, sda_q;
logic [2:0] strap_s1, strap_s2;
logic [7:0] pin_s1, pin_s2;

always_ff @(posedge clk) begin
    if (!rst_n) begin
        scl_s1 <= 1'h1;
        scl_s2 <= 1'h1;
        scl_q <= 1'h1;
        sda_s1 <= 1'h1;
        sda_s2 <= 1'h1;
        sda_q <= 1'h1;
        strap_s1 <= 3'h0;
        strap_s2 <= 3'h0;
    end else begin
        scl_s1 <= scl;
        scl_s2 <= scl_s1;
        scl_q <= scl_s2;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        sda_q <= sda_s2;
        strap_s1 <= {addr_strap_2, addr_strap_1, addr_strap_0};
        strap_s2 <= strap_s1;
    end
end

// no reset: pins keep flowing so the first snapshot sees real levels
always_ff @(posedge clk) begin
    pin_s1 <= port_pin_in;
    pin_s2 <= pin_s1;
end

logic scl_rise, scl_fall, bus_start, bus_stop;
assign scl_rise = scl_s2 & ~scl_q;
assign scl_fall = ~scl_s2 & scl_q;
assign bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
assign bus_stop = scl_s2 & scl_q & ~sda_q & sda_s2;

////////////////////////////////////////////////////////////////////////////
// protocol engine and registers

pex_state_t state, next_state;
logic [2:0] cnt, next_cnt;
logic [7:0] shreg, next_shreg;
logic [1:0] byte_idx, next_byte_idx;
logic rw, next_rw;
logic [1:0] ptr, next_ptr;
logic [7:0] outr, next_outr;
logic [7:0] pol, next_pol;
logic [7:0] dir, next_dir;
logic [7:0] in_reg, next_in_reg;
logic primed, next_primed;
logic got_bit, next_got_bit;
logic mack_ok, next_mack_ok;
logic next_sda_oe;
logic [7:0] rx_byte, rd_val;
logic wr_en, start_tx, cmd_done, addr_done, addr_match;

assign rx_byte = {shreg[6:0], link_bit};
assign addr_match = rx_byte[7:1] == {`PEX_ADDR_HI, strap_s2};

always_comb begin
    case (ptr)
        `PEX_REG_IN: rd_val = pin_s2 ^ pol;
        `PEX_REG_OUT: rd_val = outr;
        `PEX_REG_POL: rd_val = pol;
        default: rd_val = dir;
    endcase
end

always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_byte_idx = byte_idx;
    next_rw = rw;
    next_ptr = ptr;
    next_outr = outr;
    next_pol = pol;
    next_dir = dir;
    next_in_reg = in_reg;
    next_primed = 1'h1;
    next_got_bit = got_bit;
    next_mack_ok = mack_ok;
    next_sda_oe = sda_oe;
    wr_en = 1'h0;
    start_tx = 1'h0;
    cmd_done = 1'h0;
    addr_done = 1'h0;
    if (!primed) begin
        next_in_reg = pin_s2;
    end
    case (state)
        st_rx: begin
            if (scl_rise) begin
                next_shreg = rx_byte;
                next_cnt = cnt + 3'h1;
                if (cnt == `PEX_BIT_LAST) begin
                    next_state = st_ack_wait;
                    if (byte_idx != `PEX_IDX_DATA) begin
                        next_byte_idx = byte_idx + 2'h1;
                    end
                    if (byte_idx == `PEX_IDX_ADDR) begin
                        addr_done = 1'h1;
                        next_rw = rx_byte[0];
                        if (!addr_match) begin
                            next_state = st_idle;
                        end
                    end else if (byte_idx == `PEX_IDX_CMD) begin
                        cmd_done = 1'h1;
                        next_ptr = rx_byte[1:0];
                    end else begin
                        wr_en = 1'h1;
                    end
                end
            end
        end
        st_ack_wait: begin
            if (scl_fall) begin
                next_sda_oe = 1'h1;
                next_state = st_ack;
            end
        end
        st_ack: begin
            if (scl_fall) begin
                next_sda_oe = 1'h0;
                next_state = st_rx;
                start_tx = rw;
            end
        end
        st_tx: begin
            if (scl_fall) begin
                if (cnt == `PEX_BIT_LAST) begin
                    next_sda_oe = 1'h0;
                    next_got_bit = 1'h0;
                    next_state = st_mack;
                end else begin
                    next_shreg = {shreg[6:0], 1'h0};
                    next_sda_oe = ~shreg[6];
                    next_cnt = cnt + 3'h1;
                end
            end
        end
        st_mack: begin
            if (scl_rise) begin
                next_got_bit = 1'h1;
                next_mack_ok = ~link_bit;
            end
            if (scl_fall && got_bit) begin
                start_tx = mack_ok;
                next_state = st_idle;
            end
        end
        default: begin
            next_sda_oe = 1'h0;
        end
    endcase
    if (start_tx) begin
        // read target stays as last command selected
        next_shreg = rd_val;
        next_sda_oe = ~rd_val[7];
        next_cnt = 3'h0;
        next_state = st_tx;
        if (ptr == `PEX_REG_IN) begin
            next_in_reg = pin_s2;
        end
    end
    if (wr_en) begin
        case (ptr)
            `PEX_REG_OUT: next_outr = rx_byte;
            `PEX_REG_POL: next_pol = rx_byte;
            `PEX_REG_DIR: next_dir = rx_byte;
            default: ;
        endcase
    end
    // a repeated start restarts framing mid-transfer
    if (bus_start) begin
        next_state = st_rx;
        next_cnt = 3'h0;
        next_byte_idx = `PEX_IDX_ADDR;
        next_sda_oe = 1'h0;
    end else if (bus_stop) begin
        next_state = st_idle;
        next_sda_oe = 1'h0;
    end
end

always_ff @(posedge clk) begin
    if (!rst_n) begin
        state <= st_idle;
        cnt <= 3'h0;
        shreg <= 8'h00;
        byte_idx <= `PEX_IDX_ADDR;
        rw <= 1'h0;
        ptr <= `PEX_REG_IN;
        outr <= `PEX_OUT_RST;
        pol <= `PEX_POL_RST;
        dir <= `PEX_DIR_RST;
        in_reg <= 8'h00;
        primed <= 1'h0;
        got_bit <= 1'h0;
        mack_ok <= 1'h0;
        sda_oe <= 1'h0;
    end else begin
        state <= next_state;
        cnt <= next_cnt;
        shreg <= next_shreg;
        byte_idx <= next_byte_idx;
        rw <= next_rw;
        ptr <= next_ptr;
        outr <= next_outr;
        pol <= next_pol;
        dir <= next_dir;
        in_reg <= next_in_reg;
        primed <= next_primed;
        got_bit <= next_got_bit;
        mack_ok <= next_mack_ok;
        sda_oe <= next_sda_oe;
    end
end

assign sda_out = 1'h0;
assign alert_out = 1'h0;

////////////////////////////////////////////////////////////////////////////
// pin drivers and alert

logic [7:0] next_pin_oe, next_high, next_low;
logic next_alert_oe;

always_comb begin
    next_pin_oe = ~dir;
    next_high = ~dir & outr;
    next_low = ~dir & ~outr;
    // compare only against synchronised pins, never the raw inputs
    next_alert_oe = primed & (|(pin_s2 ^ in_reg));
end

always_ff @(posedge clk) begin
    if (!rst_n) begin
        port_pin_oe <= 8'h00;
        port_pin_out <= `PEX_OUT_RST;
        high_side_driver <= 8'h00;
        low_side_driver <= 8'h00;
        weak_pullup_en <= `PEX_DIR_RST;
        alert_oe <= 1'h0;
    end else begin
        port_pin_oe <= next_pin_oe;
        port_pin_out <= outr;
        high_side_driver <= next_high;
        low_side_driver <= next_low;
        weak_pullup_en <= dir;
        alert_oe <= next_alert_oe;
    end
end

////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);

AST_RESET_DEFAULTS: assert property (
    $past(!rst_n) |-> dir == `PEX_DIR_RST && pol == `PEX_POL_RST
        && outr == `PEX_OUT_RST && state == st_idle)
    else $error("registers not at defaults after reset");
AST_DIR_APPLIED: assert property (
    $past(rst_n) |-> port_pin_oe == ~$past(dir))
    else $error("pin enable does not follow direction");
AST_ONE_DRIVER: assert property (
    (high_side_driver & low_side_driver) == 8'h00
        && (high_side_driver | low_side_driver) == port_pin_oe)
    else $error("pin driver pair inconsistent");
AST_ALERT_MISMATCH: assert property (
    $past(rst_n) && primed && $past(primed)
        |-> alert_oe == (|$past(pin_s2 ^ in_reg)))
    else $error("alert does not track pin mismatch");
AST_INPUT_WRITE_IGNORED: assert property (
    wr_en && ptr == `PEX_REG_IN |=> $stable(outr) && $stable(pol)
        && $stable(dir))
    else $error("write to input register changed state");
AST_OUTPUT_LATCHED: assert property (
    !(wr_en && ptr == `PEX_REG_OUT) |=> $stable(outr))
    else $error("output register changed without a write");
AST_POLARITY_READ: assert property (
    start_tx && ptr == `PEX_REG_IN |=> shreg == ($past(pin_s2) ^ pol))
    else $error("input read ignores polarity");
AST_PTR_HELD: assert property (
    !cmd_done |=> $stable(ptr))
    else $error("register pointer moved without command");
AST_ADDR_MISS: assert property (
    addr_done && !addr_match && !bus_start |=> state == st_idle)
    else $error("foreign address acknowledged");

COV_WRITE_OUT: cover property (wr_en && ptr == `PEX_REG_OUT);
COV_READ_IN: cover property (start_tx && ptr == `PEX_REG_IN);
COV_WRITE_IN: cover property (wr_en && ptr == `PEX_REG_IN);
COV_ALERT: cover property ($rose(alert_oe));

endmodule

// ===== pex_i2c_master.sv
// serial bus master model facing the expander's link
`timescale 1ns/1ps
module pex_i2c_master (
    // link, open drain: sda_low high pulls the data line down
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // 48 ns per bit, data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #12 scl = 1'b1;
        #24 r = sda;
        scl = 1'b0;
        #12;
    endtask
    // also serves as repeated start
    task automatic start();
        sda_low = 1'b0;
        #12 scl = 1'b1;
        #24 sda_low = 1'b1;
        #24 scl = 1'b0;
        #12;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #12 scl = 1'b1;
        #24 sda_low = 1'b0;
        #24;
    endtask
    // msb first; d of ff releases the line for a read
    task automatic xfer(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(m_ack, ack);
    endtask
endmodule

// ===== i2c_octal_port_expander_bench.sv
// self-checking bench of the octal port expander
`timescale 1ns/1ps
`include "pex_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module i2c_octal_port_expander_bench;
    import pex_pkg::*;
    logic clk, rst_n, ack;
    logic [2:0] strap;
    logic [7:0] ext, dir, outv, pol, q;
    int error_cnt, checks;
    wire scl, sda_low, sda_oe, sda_out, alert_out, alert_oe;
    wire [7:0] pin_out, pin_oe, hi_drv, lo_drv, pull_en, pins;
    // released sda floats high through its pull-up
    wire sda = ~(sda_low | sda_oe);
    // undriven pins take the external level
    assign pins = (pin_oe & pin_out) | (~pin_oe & ext);
    pex_i2c_master u_pex_i2c_master (.scl(scl), .sda_low(sda_low),
        .sda(sda));
    pex_port_expander u_pex_port_expander (.clk(clk), .rst_n(rst_n),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
        .addr_strap_2(strap[2]), .port_pin_in(pins),
        .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .high_side_driver(hi_drv), .low_side_driver(lo_drv),
        .weak_pullup_en(pull_en), .alert_out(alert_out),
        .alert_oe(alert_oe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] f_pin(input logic [7:0] d, o, e);
        return (~d & o) | (d & e);
    endfunction
    task automatic test_done();
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wreg(input logic [1:0] p, input logic [7:0] v);
        logic a1, a2, a3;
        u_pex_i2c_master.start();
        u_pex_i2c_master.xfer({`PEX_ADDR_HI, strap, 1'b0}, 1'b1, q, a1);
        u_pex_i2c_master.xfer({6'h00, p}, 1'b1, q, a2);
        u_pex_i2c_master.xfer(v, 1'b1, q, a3);
        u_pex_i2c_master.stop();
        `CHK({a1, a2, a3}, 3'h0)
    endtask
    // ptr low reads through the pointer left by earlier frames
    task automatic rreg(input logic [1:0] p, input logic ptr);
        if (ptr) begin
            u_pex_i2c_master.start();
            u_pex_i2c_master.xfer({`PEX_ADDR_HI, strap, 1'b0}, 1'b1, q, ack);
            u_pex_i2c_master.xfer({6'h00, p}, 1'b1, q, ack);
        end
        u_pex_i2c_master.start();
        u_pex_i2c_master.xfer({`PEX_ADDR_HI, strap, 1'b1}, 1'b1, q, ack);
        `CHK(ack, 1'b0)
        u_pex_i2c_master.xfer(8'hff, 1'b1, q, ack);
        u_pex_i2c_master.stop();
    endtask
    task automatic chk_pins();
        #20;
        `CHK(pin_oe, ~dir)
        `CHK(hi_drv, ~dir & outv)
        `CHK(lo_drv, ~dir & ~outv)
        `CHK(pull_en, dir)
        `CHK(pin_out, outv)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        strap = 3'h0;
        ext = 8'h5a;
        dir = 8'hff;
        outv = 8'hff;
        pol = 8'h00;
        error_cnt = 0;
        checks = 0;
        void'($urandom(23));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge clk);
        chk_pins();
        `CHK({sda_oe, alert_oe}, 2'h0)
        `CHK({sda_out, alert_out}, 2'h0)
        // each strap setting answers, the address with inverted straps stays silent
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            #1 strap = s[2:0];
            rreg(`PEX_REG_DIR, 1'b1);
            `CHK(q, dir)
            u_pex_i2c_master.start();
            u_pex_i2c_master.xfer({`PEX_ADDR_HI, ~strap, 1'b0}, 1'b1, q, ack);
            u_pex_i2c_master.stop();
            `CHK(ack, 1'b1)
        end
        // first pass is the all-output, all-inverted corner
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            #1 ext = 8'($urandom);
            outv = 8'($urandom);
            dir = i == 0 ? 8'h00 : 8'($urandom);
            pol = i == 0 ? 8'hff : 8'($urandom);
            wreg(`PEX_REG_OUT, outv);
            wreg(`PEX_REG_POL, pol);
            wreg(`PEX_REG_DIR, dir);
            chk_pins();
            rreg(`PEX_REG_OUT, 1'b1);
            `CHK(q, outv)
            rreg(`PEX_REG_POL, 1'b1);
            `CHK(q, pol)
            rreg(`PEX_REG_IN, 1'b1);
            `CHK(q, f_pin(dir, outv, ext) ^ pol)
            rreg(`PEX_REG_IN, 1'b0);
            `CHK(q, f_pin(dir, outv, ext) ^ pol)
            wreg(`PEX_REG_IN, ~outv);
            rreg(`PEX_REG_OUT, 1'b1);
            `CHK(q, outv)
        end
        // burst: high command bits ignored, last byte wins, reads repeat
        u_pex_i2c_master.start();
        u_pex_i2c_master.xfer({`PEX_ADDR_HI, strap, 1'b0}, 1'b1, q, ack);
        u_pex_i2c_master.xfer({6'($urandom), `PEX_REG_POL}, 1'b1, q, ack);
        u_pex_i2c_master.xfer(~pol, 1'b1, q, ack);
        u_pex_i2c_master.xfer(pol, 1'b1, q, ack);
        `CHK(ack, 1'b0)
        u_pex_i2c_master.start();
        u_pex_i2c_master.xfer({`PEX_ADDR_HI, strap, 1'b1}, 1'b1, q, ack);
        u_pex_i2c_master.xfer(8'hff, 1'b0, q, ack);
        `CHK(q, pol)
        u_pex_i2c_master.xfer(8'hff, 1'b1, q, ack);
        u_pex_i2c_master.stop();
        `CHK(q, pol)
        // alert: raised by a pin change, only after synchronising
        dir = 8'hff;
        wreg(`PEX_REG_DIR, dir);
        rreg(`PEX_REG_IN, 1'b1);
        `CHK(alert_oe, 1'b0)
        @(posedge clk);
        #1 ext = ~ext;
        @(posedge clk);
        #1 `CHK(alert_oe, 1'b0)
        for (int k = 0; k < 8 && alert_oe !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        `CHK(alert_oe, 1'b1)
        if (alert_oe !== 1'b1) begin
            test_done();
        end
        rreg(`PEX_REG_IN, 1'b1);
        `CHK(alert_oe, 1'b0)
        // reset in mid-frame restores defaults and the pointer
        wreg(`PEX_REG_OUT, 8'h00);
        wreg(`PEX_REG_DIR, 8'h00);
        u_pex_i2c_master.start();
        u_pex_i2c_master.xfer({`PEX_ADDR_HI, strap, 1'b0}, 1'b1, q, ack);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        u_pex_i2c_master.stop();
        outv = 8'hff;
        chk_pins();
        rreg(`PEX_REG_OUT, 1'b0);
        `CHK(q, ext)
        rreg(`PEX_REG_POL, 1'b1);
        `CHK(q, 8'h00)
        test_done();
    end
endmodule
